//--- src/ccoc_pkg.sv
/*
  Shared constants for the cache coherence operation control block.
  Assumes a single core clock domain and an active-low asynchronous reset.
*/
`default_nettype none
package ccoc_pkg;
  localparam int ADDR_W = 32;
  localparam int WC_W = 16;
  // Global operation selectors
  localparam logic [1:0] GSEL_L1_INV = 2'h0;
  localparam logic [1:0] GSEL_L1_FLINV = 2'h1;
  localparam logic [1:0] GSEL_L2_INV = 2'h2;
  localparam logic [1:0] GSEL_L2_FLINV = 2'h3;
  // Block operation kinds
  localparam logic [1:0] BOP_WB = 2'h0;
  localparam logic [1:0] BOP_INV = 2'h1;
  localparam logic [1:0] BOP_WRITEBACK_INVALIDATE_OP = 2'h2;
  localparam logic [ADDR_W-1:0] BAR_RST = 32'h0000_0000;
  localparam logic [WC_W-1:0] WC_RST = 16'h0000;
  // Cycles the memory system spends per word of a block operation
  localparam int WORD_CYC = 1;
  // Cycles for a global operation to sweep the cache
  localparam int GLOBAL_CYC = 64;
  // Quiet cycles after completion before interrupts return
  localparam int QUIET_NOPS = 16;
  localparam int GCNT_W = 8;
  localparam logic [GCNT_W-1:0] GLOBAL_CNT = GCNT_W'(GLOBAL_CYC);
  localparam logic [4:0] QUIET_CNT = 5'(QUIET_NOPS);
endpackage : ccoc_pkg
`default_nettype wire

//--- src/ccoc_if.sv
/*
  Interface joining the software side (core) and the coherence controller.
  Assumes both ends share mclk_i.
*/
`default_nettype none
interface ccoc_if;
  logic bar_wr;
  logic [31:0] bar_wdata;
  logic wc_wr;
  logic [1:0] wc_kind;
  logic wc_l2;
  logic [15:0] wc_wdata;
  logic [15:0] wc_rdata;
  logic g_wr;
  logic [1:0] g_sel;
  logic g_wdata;
  logic [3:0] g_rdata;
  logic fence_req;
  logic fence_stall;
  logic hazard_exposed;
  modport ctrl (
    input bar_wr, bar_wdata, wc_wr, wc_kind, wc_l2, wc_wdata, g_wr, g_sel, g_wdata,
    input fence_req,
    output wc_rdata, g_rdata, fence_stall, hazard_exposed
  );
  modport core (
    output bar_wr, bar_wdata, wc_wr, wc_kind, wc_l2, wc_wdata, g_wr, g_sel, g_wdata,
    output fence_req,
    input wc_rdata, g_rdata, fence_stall, hazard_exposed
  );
endinterface : ccoc_if
`default_nettype wire

//--- src/ccoc_ctrl.sv
/*
  Device end: block and global coherence engine with completion reporting.
  Assumes the core end writes base before count and honours the fence stall.
*/
`default_nettype none
// How it works
// - Base address written before word count
// - Word count nonzero while running, zero done
// - Writing one starts global operation
// - Selected global bit set until finished
// - Idle style masks interrupts, waits for completion
// - Sixteen quiet cycles before interrupts return
// - Fence stalls until all operations complete
// - Pure writebacks free of set hazard
// - Freeze, flush-invalidate, poll count, unfreeze
// - Back-to-back set accesses risk corruption
module ccoc_ctrl (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Link
  ccoc_if.ctrl bus,
  // Memory system view
  output logic [31:0] cur_addr_o,
  output logic block_busy_o,
  output logic [3:0] global_busy_o
);
  typedef enum logic [1:0] {
    CCOC_IDLE = 2'b01,
    CCOC_RUN = 2'b10
  } ccoc_bstate_t;
  ccoc_bstate_t bstate_q;
  logic [31:0] bar_q;
  logic [15:0] wc_q;
  logic [1:0] kind_q;
  logic [7:0] pace_q;
  logic [3:0] gbusy_q;
  logic [ccoc_pkg::GCNT_W-1:0] gcnt_q [4];
  logic stall_q;
  logic hazard_q;
  logic blk_busy_q;
  logic blk_start;
  logic blk_last;
  logic word_step;
  logic pend_start;
  logic any_busy;
  logic [3:0] glb_start;
  logic [3:0] glb_last;

  // launch on count write
  // Zero counts refused, so a busy count never reads zero
  always_comb begin
    blk_start = 1'b0;
    if (bus.wc_wr && bus.wc_wdata != 16'h0000 && bstate_q == CCOC_IDLE) begin
      blk_start = 1'b1;
    end
  end

  // Word pacing, one word per paced slot
  always_comb begin
    word_step = 1'b0;
    if (bstate_q == CCOC_RUN && pace_q == 8'h00) begin
      word_step = 1'b1;
    end
  end

  always_comb begin
    blk_last = 1'b0;
    if (word_step && wc_q == 16'h0001) begin
      blk_last = 1'b1;
    end
  end

  always_comb begin
    glb_start = 4'h0;
    glb_last = 4'h0;
    for (int i = 0; i < 4; i++) begin
      glb_start[i] = bus.g_wr && bus.g_wdata && bus.g_sel == 2'(i) && !gbusy_q[i];
      glb_last[i] = gbusy_q[i] && gcnt_q[i] == 8'h01;
    end
  end

  always_comb begin
    pend_start = blk_start || (glb_start != 4'h0);
    any_busy = (bstate_q == CCOC_RUN) || (gbusy_q != 4'h0) || pend_start;
  end

  // Base address register
  // Steps per drained word so the sweep address stays visible
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bar_q <= ccoc_pkg::BAR_RST;
    end else if (bus.bar_wr && bstate_q == CCOC_IDLE) begin
      bar_q <= bus.bar_wdata;
    end else if (word_step) begin
      bar_q <= bar_q + 32'h0000_0004;
    end
  end

  // Pacing counter
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pace_q <= 8'h00;
    end else if (blk_start || word_step) begin
      pace_q <= 8'(ccoc_pkg::WORD_CYC - 1);
    end else if (bstate_q == CCOC_RUN) begin
      pace_q <= pace_q - 8'h01;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bstate_q <= CCOC_IDLE;
    end else begin
      case (bstate_q)
        CCOC_IDLE: begin
          if (blk_start) begin
            bstate_q <= CCOC_RUN;
          end
        end
        CCOC_RUN: begin
          if (blk_last) begin
            bstate_q <= CCOC_IDLE;
          end
        end
        default: begin
          bstate_q <= CCOC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wc_q <= ccoc_pkg::WC_RST;
    end else if (blk_start) begin
      wc_q <= bus.wc_wdata;
    end else if (word_step) begin
      wc_q <= wc_q - 16'h0001;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      kind_q <= ccoc_pkg::BOP_WB;
    end else if (blk_start) begin
      kind_q <= bus.wc_kind;
    end
  end

  // Output flop tracks the run state
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blk_busy_q <= 1'b0;
    end else begin
      blk_busy_q <= blk_start || (bstate_q == CCOC_RUN && !blk_last);
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_glob
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        gbusy_q[g] <= 1'b0;
      end else if (glb_start[g]) begin
        gbusy_q[g] <= 1'b1;
      end else if (glb_last[g]) begin
        gbusy_q[g] <= 1'b0;
      end
    end
    // Sweep length counter
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        gcnt_q[g] <= '0;
      end else if (glb_start[g]) begin
        gcnt_q[g] <= ccoc_pkg::GLOBAL_CNT;
      end else if (gbusy_q[g]) begin
        gcnt_q[g] <= gcnt_q[g] - 8'h01;
      end
    end
  end

  // fence stall until idle
  // Registered, so the core trusts it one cycle after raising a fence
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stall_q <= 1'b0;
    end else begin
      stall_q <= bus.fence_req && any_busy;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hazard_q <= 1'b0;
    end else begin
      hazard_q <= (bstate_q == CCOC_RUN && kind_q != ccoc_pkg::BOP_WB) || gbusy_q != 4'h0;
    end
  end

  // Outputs registered; wc read is the live count
  assign bus.wc_rdata = wc_q;
  assign bus.g_rdata = gbusy_q;
  assign bus.fence_stall = stall_q;
  assign bus.hazard_exposed = hazard_q;
  assign cur_addr_o = bar_q;
  assign block_busy_o = blk_busy_q;
  assign global_busy_o = gbusy_q;
endmodule : ccoc_ctrl
`default_nettype wire

//--- src/ccoc_core.sv
/*
  Core end: issues safe coherence sequences (idle or parallel style).
  Assumes the controller end drives count, busy bits and fence stall.
*/
`default_nettype none
module ccoc_core (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Link
  ccoc_if.core bus,
  // User request
  input wire logic req_i,
  input wire logic req_global_i,
  input wire logic req_parallel_i,
  input wire logic [1:0] req_sel_i,
  input wire logic [31:0] req_addr_i,
  input wire logic [15:0] req_wc_i,
  // Status
  output logic busy_o,
  output logic int_en_o,
  output logic l1_freeze_o,
  output logic done_o
);
  typedef enum logic [7:0] {
    CCOR_IDLE = 8'h01, CCOR_BAR = 8'h02, CCOR_WC = 8'h04, CCOR_GLB = 8'h08,
    CCOR_WAIT = 8'h10, CCOR_FENCE = 8'h20, CCOR_QUIET = 8'h40, CCOR_PRE = 8'h80
  } ccoc_cstate_t;
  ccoc_cstate_t st_q;
  logic glob_q, par_q, bar_wr_q, wc_wr_q, g_wr_q, fence_q;
  logic fence_arm_q;
  logic [1:0] sel_q;
  logic [31:0] addr_q;
  logic [15:0] wc_q;
  logic [4:0] nop_q;
  logic busy_q, int_en_q, frz_q, done_q;
  logic op_done;
  assign op_done = glob_q ? (bus.g_rdata[sel_q] == 1'b0) : (bus.wc_rdata == 16'h0000);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= CCOR_IDLE;
      {glob_q, par_q, bar_wr_q, wc_wr_q, g_wr_q, fence_q} <= 6'h00;
      fence_arm_q <= 1'b0;
      sel_q <= 2'h0;
      addr_q <= 32'h0000_0000;
      wc_q <= 16'h0000;
      nop_q <= 5'h00;
      {busy_q, frz_q, done_q} <= 3'h0;
      int_en_q <= 1'b1;
    end else begin
      {bar_wr_q, wc_wr_q, g_wr_q, done_q} <= 4'h0;
      // Stall lags the fence by a cycle, so trust it only once armed
      fence_arm_q <= fence_q;
      case (st_q)
        CCOR_IDLE: begin
          if (req_i) begin
            glob_q <= req_global_i;
            par_q <= req_parallel_i;
            sel_q <= req_sel_i;
            addr_q <= req_addr_i;
            wc_q <= req_wc_i;
            busy_q <= 1'b1;
            int_en_q <= req_parallel_i;
            fence_q <= req_parallel_i;
            st_q <= req_parallel_i ? CCOR_PRE : (req_global_i ? CCOR_GLB : CCOR_BAR);
          end
        end
        CCOR_PRE: begin
          if (fence_arm_q && !bus.fence_stall) begin
            fence_q <= 1'b0;
            frz_q <= 1'b1;
            st_q <= CCOR_BAR;
          end
        end
        CCOR_BAR: begin
          bar_wr_q <= 1'b1;
          st_q <= CCOR_WC;
        end
        CCOR_WC: begin
          wc_wr_q <= 1'b1;
          st_q <= CCOR_WAIT;
        end
        CCOR_GLB: begin
          g_wr_q <= 1'b1;
          st_q <= CCOR_WAIT;
        end
        CCOR_WAIT: begin
          if (!wc_wr_q && !g_wr_q && (!par_q || op_done)) begin
            fence_q <= 1'b1;
            st_q <= CCOR_FENCE;
          end
        end
        CCOR_FENCE: begin
          if (fence_arm_q && !bus.fence_stall) begin
            fence_q <= 1'b0;
            frz_q <= 1'b0;
            nop_q <= ccoc_pkg::QUIET_CNT;
            st_q <= CCOR_QUIET;
          end
        end
        CCOR_QUIET: begin
          nop_q <= nop_q - 5'h01;
          if (nop_q == 5'h01) begin
            int_en_q <= 1'b1;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            st_q <= CCOR_IDLE;
          end
        end
        default: begin
          st_q <= CCOR_IDLE;
        end
      endcase
    end
  end

  assign bus.bar_wr = bar_wr_q;
  assign bus.bar_wdata = addr_q;
  assign bus.wc_wr = wc_wr_q;
  assign bus.wc_kind = par_q ? ccoc_pkg::BOP_WRITEBACK_INVALIDATE_OP : ccoc_pkg::BOP_INV;
  assign bus.wc_l2 = 1'b0;
  assign bus.wc_wdata = wc_q;
  assign bus.g_wr = g_wr_q;
  assign bus.g_sel = sel_q;
  assign bus.g_wdata = 1'b1;
  assign bus.fence_req = fence_q;
  assign busy_o = busy_q;
  assign int_en_o = int_en_q;
  assign l1_freeze_o = frz_q;
  assign done_o = done_q;
endmodule : ccoc_core
`default_nettype wire

//--- dv/ccoc_props.sv
/* Checker for the coherence link signals.
   Assumes it is instantiated beside the link in the bench. */
`default_nettype none
module ccoc_props (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Link
  input wire logic bar_wr_i,
  input wire logic wc_wr_i,
  input wire logic [15:0] wc_wdata_i,
  input wire logic [15:0] wc_rdata_i,
  input wire logic g_wr_i,
  input wire logic [1:0] g_sel_i,
  input wire logic g_wdata_i,
  input wire logic [3:0] g_rdata_i,
  input wire logic fence_req_i,
  input wire logic fence_stall_i,
  input wire logic hazard_exposed_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic busy;
  assign busy = (wc_rdata_i != 16'h0) || (g_rdata_i != 4'h0);
  a_wc_load_count: assert property (
    wc_wr_i && wc_wdata_i != 16'h0 && !busy |=> wc_rdata_i == $past(wc_wdata_i))
    else $error("count not loaded");
  a_wc_count_down: assert property (
    wc_rdata_i != 16'h0 |=> wc_rdata_i == $past(wc_rdata_i) - 16'h1)
    else $error("count not stepping");
  a_glb_bit_start: assert property (
    g_wr_i && g_wdata_i && g_rdata_i == 4'h0 |=> g_rdata_i[$past(g_sel_i)])
    else $error("global op not started");
  a_glb_bit_hold: assert property (
    $rose(g_rdata_i != 4'h0) |-> (g_rdata_i != 4'h0) [*8])
    else $error("global bit dropped early");
  a_glb_bit_end: assert property (
    $rose(g_rdata_i != 4'h0) |-> ##[63:65] g_rdata_i == 4'h0)
    else $error("global bit not cleared");
  a_fence_stall_on: assert property (
    fence_req_i && busy |=> fence_stall_i)
    else $error("fence did not stall");
  a_fence_stall_cause: assert property (
    fence_stall_i |-> $past(fence_req_i) && $past(busy))
    else $error("fence stalled without cause");
  a_hazard_flag_on: assert property (
    $rose(busy) |=> hazard_exposed_i)
    else $error("hazard flag missing");
  a_base_before_count: assert property (
    wc_wr_i |-> $past(bar_wr_i))
    else $error("count written before base");
  c_block_run: cover property ($rose(wc_rdata_i != 16'h0));
  c_global_run: cover property (g_wr_i && g_wdata_i);
  c_fence_stall: cover property ($rose(fence_stall_i));
endmodule // ccoc_props
`default_nettype wire

//--- dv/tb.sv
/* Bench: core end drives the controller end over the link.
   Assumes only the two design ends, the link and the checker. */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_i = 1'b0;
  logic req_global_i = 1'b0;
  logic req_parallel_i = 1'b0;
  logic [1:0] req_sel_i = 2'h0;
  logic [31:0] req_addr_i = 32'h0000_1000;
  logic [15:0] req_wc_i = 16'h0000;
  logic busy_o, int_en_o, l1_freeze_o, done_o, block_busy_o;
  logic [31:0] cur_addr_o;
  logic [3:0] global_busy_o;
  int err_count = 0;
  int tests_run = 0;
  ccoc_if bus ();
  ccoc_ctrl ccoc_ctrl_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus(bus),
    .cur_addr_o(cur_addr_o), .block_busy_o(block_busy_o), .global_busy_o(global_busy_o));
  ccoc_core ccoc_core_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus(bus), .req_i(req_i),
    .req_global_i(req_global_i), .req_parallel_i(req_parallel_i), .req_sel_i(req_sel_i),
    .req_addr_i(req_addr_i), .req_wc_i(req_wc_i), .busy_o(busy_o), .int_en_o(int_en_o),
    .l1_freeze_o(l1_freeze_o), .done_o(done_o));
  ccoc_props ccoc_props_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bar_wr_i(bus.bar_wr),
    .wc_wr_i(bus.wc_wr), .wc_wdata_i(bus.wc_wdata), .wc_rdata_i(bus.wc_rdata),
    .g_wr_i(bus.g_wr), .g_sel_i(bus.g_sel), .g_wdata_i(bus.g_wdata),
    .g_rdata_i(bus.g_rdata), .fence_req_i(bus.fence_req), .fence_stall_i(bus.fence_stall),
    .hazard_exposed_i(bus.hazard_exposed));
  initial forever #10 mclk_i = ~mclk_i;
  task automatic wrap_up();
    $display("err_count=%0d tests_run=%0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Runs one request to done; seen = {irq off, freeze, block busy, selected global busy}
  task automatic run(input logic g, input logic p, input logic [1:0] s, input logic [15:0] n,
    output logic [31:0] quiet, output logic [3:0] seen);
    quiet = 32'h0;
    seen = 4'h0;
    @(posedge mclk_i);
    req_i <= 1'b1;
    req_global_i <= g;
    req_parallel_i <= p;
    req_sel_i <= s;
    req_wc_i <= n;
    @(posedge mclk_i);
    req_i <= 1'b0;
    for (int i = 0; i < 400 && done_o !== 1'b1; i++) begin
      @(posedge mclk_i);
      #1;
      seen = seen | {!int_en_o, l1_freeze_o, block_busy_o, global_busy_o[s]};
      // Idle run length; the core must sit quiet before it lets interrupts back
      quiet = ((bus.wc_rdata | bus.g_rdata) != 16'h0) ? 32'h0 : quiet + 32'h1;
    end
    chk(done_o, 32'h1);
    chk(busy_o, 32'h0);
  endtask
  task automatic t_block();
    logic [31:0] q;
    logic [3:0] sn;
    run(1'b0, 1'b0, 2'h0, 16'h0005, q, sn);
    chk(sn, 32'hA);
    chk(cur_addr_o, 32'h0000_1000 + 32'h0000_0014);
    chk(q >= 32'h10, 32'h1);
    @(posedge mclk_i);
    #1;
    chk(int_en_o, 32'h1);
  endtask
  task automatic t_global();
    logic [31:0] q;
    logic [3:0] sn;
    for (int s = 0; s < 4; s++) begin
      run(1'b1, 1'b0, s[1:0], 16'h0000, q, sn);
      chk(sn, 32'h9);
      chk(q >= 32'h10, 32'h1);
    end
  endtask
  task automatic t_parallel();
    logic [31:0] q;
    logic [3:0] sn;
    run(1'b0, 1'b1, 2'h0, 16'h0006, q, sn);
    chk(sn, 32'h6);
    @(posedge mclk_i);
    #1;
    chk(l1_freeze_o, 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_block();
    t_global();
    t_parallel();
    wrap_up();
  end
  // Six runs of at most 400 cycles each fit well inside this span
  initial begin
    #100us;
    err_count++;
    wrap_up();
  end
endmodule // tb
`default_nettype wire
